// ---- include/dpwdt_pkg.sv ----
/*
  shared constants and carrier types of the dual postscaler watchdog timer.
  assumes a 16-bit register port with byte addresses on a 4-bit address.
*/
package dpwdt_pkg;
  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int DW = 16;
  localparam int AW = 4;
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_KEY  = 4'h4;
  localparam logic [AW-1:0] ADDR_STAT = 4'h8;
  localparam logic [AW-1:0] ADDR_MASK = 4'hc;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int ON_BIT     = 15;
  localparam int RUN_DIV_LSB = 8;
  localparam int CLK_SEL_LSB = 6;
  localparam int SLP_DIV_LSB = 1;
  localparam int WIN_BIT    = 0;
  localparam int DIV_W      = 5;
  localparam int CNT_MIN_W  = 32;

  localparam logic [DW-1:0] CLEAR_KEY = 16'h5743;
  localparam logic [DW-1:0] RD_ZERO   = 16'h0000;

  localparam logic [1:0] CS_SYS  = 2'h0;
  localparam logic [1:0] CS_RSVD = 2'h1;
  localparam logic [1:0] CS_FCLK  = 2'h2;
  localparam logic [1:0] CS_LPCLK = 2'h3;

  // ----------------------------------------
  // status and mask bits
  // ----------------------------------------
  localparam int ST_W     = 3;
  localparam int ST_RESET = 0;
  localparam int ST_WAKE  = 1;
  localparam int ST_EARLY = 2;
  localparam logic [ST_W-1:0] ST_RST_VAL = 3'h0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic             en;
    logic             win;
    logic [DIV_W-1:0] run_div;
    logic [1:0]       clk_sel;
    logic [DIV_W-1:0] slp_div;
  } dpwdt_cfg_s;

  localparam dpwdt_cfg_s CFG_RST_VAL = '0;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } dpwdt_bus_s;
endpackage

// ---- design/dpwdt_top.sv ----
/*
  dual postscaler watchdog timer: run and sleep/idle time-outs, window mode,
  clear key, reset cause flag and interrupt status.
  assumes config bits are steady at the first enabled clock after reset, oscillator inputs are
  asynchronous pins, and power_save and the bus come from clk_sys logic.
*/
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module dpwdt_top
  import dpwdt_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock, reset, enable
  input  logic          clk_sys,
  input  logic          rst,
  input  logic          ce,
  // configuration bits, caught after reset
  input  dpwdt_cfg_s    cfg_bits,
  // power state
  input  logic          power_save,
  // oscillator pins
  input  logic          lpclk_in,
  input  logic          fclk_in,
  // register port
  input  dpwdt_bus_s    bus,
  output logic [DW-1:0] rd_data,
  // reset cause
  input  logic          cause_clr,
  output logic          watchdog_reset_flag,
  // events
  output logic          dev_reset,
  output logic          wake_req,
  output logic          irq
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (CNT_W < CNT_MIN_W) begin : g_chk
    $error("counter too narrow for the longest postscale");
  end

  // ----------------------------------------
  // oscillator synchronisers
  // ----------------------------------------
  logic lpclk_s1, lpclk_s2, lpclk_s3;
  logic fclk_s1, fclk_s2, fclk_s3;
  logic lpclk_rise, fclk_rise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lpclk_s1 <= 1'b0;
      lpclk_s2 <= 1'b0;
      lpclk_s3 <= 1'b0;
      fclk_s1  <= 1'b0;
      fclk_s2  <= 1'b0;
      fclk_s3  <= 1'b0;
    end else if (ce) begin
      lpclk_s1 <= lpclk_in;
      lpclk_s2 <= lpclk_s1;
      lpclk_s3 <= lpclk_s2;
      fclk_s1  <= fclk_in;
      fclk_s2  <= fclk_s1;
      fclk_s3  <= fclk_s2;
    end
  end

  assign lpclk_rise = lpclk_s2 & ~lpclk_s3;
  assign fclk_rise  = fclk_s2 & ~fclk_s3;

  // ----------------------------------------
  // configuration capture
  // ----------------------------------------
  dpwdt_cfg_s cfg_q, next_cfg_q;
  logic       cfg_loaded, next_cfg_loaded;

  always_comb begin
    next_cfg_q      = cfg_q;
    next_cfg_loaded = 1'b1;
    if (!cfg_loaded) begin
      next_cfg_q = cfg_bits;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q      <= CFG_RST_VAL;
      cfg_loaded <= 1'b0;
    end else if (ce) begin
      cfg_q      <= next_cfg_q;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  // ----------------------------------------
  // software control
  // ----------------------------------------
  logic          sw_en, next_sw_en;
  logic          sw_win, next_sw_win;
  logic [ST_W-1:0] mask, next_mask;
  logic          running, win_en;
  logic          wr_ctrl, key_ok;

  assign wr_ctrl = bus.wr && bus.addr == ADDR_CTRL;
  assign key_ok  = bus.wr && bus.addr == ADDR_KEY && bus.wdata == CLEAR_KEY;
  assign running = cfg_q.en | sw_en;
  assign win_en  = cfg_q.win | sw_win;

  always_comb begin
    next_sw_en  = sw_en;
    next_sw_win = sw_win;
    next_mask   = mask;
    if (wr_ctrl) begin
      next_sw_en  = bus.wdata[ON_BIT];
      next_sw_win = bus.wdata[WIN_BIT];
    end
    if (bus.wr && bus.addr == ADDR_MASK) begin
      next_mask = bus.wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_en  <= 1'b0;
      sw_win <= 1'b0;
      mask   <= ST_RST_VAL;
    end else if (ce) begin
      sw_en  <= next_sw_en;
      sw_win <= next_sw_win;
      mask   <= next_mask;
    end
  end

  // ----------------------------------------
  // count clock and time-out
  // ----------------------------------------
  logic             tick;
  logic [DIV_W-1:0] div;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] count, next_count;
  logic             ps_q;
  logic             win_open, expire, early;

  always_comb begin
    if (power_save || cfg_q.clk_sel == CS_LPCLK) begin
      tick = lpclk_rise;
    end else if (cfg_q.clk_sel == CS_FCLK) begin
      tick = fclk_rise;
    end else if (cfg_q.clk_sel == CS_SYS) begin
      tick = 1'b1;
    end else begin
      tick = 1'b0;
    end
  end

  assign div      = power_save ? cfg_q.slp_div : cfg_q.run_div;
  assign limit    = ~({CNT_W{1'b1}} << div);
  assign win_open = count >= (limit >> 1);
  assign expire   = running && tick && count == limit && ps_q == power_save;
  assign early    = key_ok && running && win_en && !power_save && !win_open;

  always_comb begin
    next_count = count;
    if (!running || key_ok || expire || ps_q != power_save) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= '0;
      ps_q  <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      ps_q  <= power_save;
    end
  end

  // ----------------------------------------
  // events, status and reset cause
  // ----------------------------------------
  logic            next_dev_reset, next_wake_req, next_flag;
  logic [ST_W-1:0] stat, next_stat, ev;

  always_comb begin
    next_dev_reset = (expire && !power_save) || early;
    next_wake_req  = expire && power_save;
    next_flag      = next_dev_reset || (watchdog_reset_flag && !cause_clr);
    ev             = '0;
    ev[ST_RESET]   = next_dev_reset;
    ev[ST_WAKE]    = next_wake_req;
    ev[ST_EARLY]   = early;
    next_stat      = stat;
    if (bus.rd && bus.addr == ADDR_STAT) begin
      next_stat = '0;
    end
    next_stat = next_stat | ev;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dev_reset           <= 1'b0;
      wake_req            <= 1'b0;
      watchdog_reset_flag <= 1'b0;
      stat                <= ST_RST_VAL;
    end else if (ce) begin
      dev_reset           <= next_dev_reset;
      wake_req            <= next_wake_req;
      watchdog_reset_flag <= next_flag;
      stat                <= next_stat;
    end
  end

  assign irq = |(stat & mask);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [DW-1:0] next_rd_data;

  always_comb begin
    next_rd_data = RD_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: begin
          next_rd_data[ON_BIT]                          = running;
          next_rd_data[RUN_DIV_LSB +: DIV_W]            = cfg_q.run_div;
          next_rd_data[CLK_SEL_LSB +: 2]                = cfg_q.clk_sel;
          next_rd_data[SLP_DIV_LSB +: DIV_W]            = cfg_q.slp_div;
          next_rd_data[WIN_BIT]                         = win_en;
        end
        ADDR_STAT: begin
          next_rd_data[ST_W-1:0] = stat;
        end
        ADDR_MASK: begin
          next_rd_data[ST_W-1:0] = mask;
        end
        default: begin
          next_rd_data = RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= RD_ZERO;
    end else if (ce) begin
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_run_expiry;
    ce && running && tick && count == limit && !power_save && ps_q == power_save;
  endsequence

  sequence s_key;
    ce && key_ok && !early;
  endsequence

  property p_reset_on_expiry;
    s_run_expiry |=> dev_reset && !wake_req;
  endproperty
  a_reset_on_expiry: assert property (p_reset_on_expiry)
    else $error("run expiry gave no device reset");

  property p_flag_with_reset;
    dev_reset |-> watchdog_reset_flag;
  endproperty
  a_flag_with_reset: assert property (p_flag_with_reset)
    else $error("device reset without cause flag");

  property p_wake_in_save;
    ce && running && tick && count == limit && power_save && ps_q |=> wake_req && !dev_reset;
  endproperty
  a_wake_in_save: assert property (p_wake_in_save)
    else $error("save-mode expiry did not wake");

  property p_save_uses_lpclk;
    ce && power_save && ps_q && !lpclk_rise |=> count == $past(count) || count == '0;
  endproperty
  a_save_uses_lpclk: assert property (p_save_uses_lpclk)
    else $error("save-mode count moved without low-power edge");

  property p_sys_clock_counts;
    ce && running && !power_save && !ps_q && cfg_q.clk_sel == CS_SYS && count < limit && !key_ok
      |=> count == $past(count) + 1'b1;
  endproperty
  a_sys_clock_counts: assert property (p_sys_clock_counts)
    else $error("system clock select did not count");

  property p_run_bound;
    running && !power_save && !ps_q |-> count <= ~({CNT_W{1'b1}} << cfg_q.run_div);
  endproperty
  a_run_bound: assert property (p_run_bound)
    else $error("run count beyond postscale");

  property p_save_bound;
    running && power_save && ps_q |-> count <= ~({CNT_W{1'b1}} << cfg_q.slp_div);
  endproperty
  a_save_bound: assert property (p_save_bound)
    else $error("save count beyond postscale");

  property p_cfg_frozen;
    cfg_loaded |=> $stable(cfg_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("mirrored config changed");

  property p_cfg_en_holds;
    ce && wr_ctrl && cfg_q.en |=> running;
  endproperty
  a_cfg_en_holds: assert property (p_cfg_en_holds)
    else $error("software stopped a configured watchdog");

  property p_on_reads_running;
    ce && bus.rd && bus.addr == ADDR_CTRL |=> rd_data[ON_BIT] == $past(running) && rd_data[14:13] == 2'h0;
  endproperty
  a_on_reads_running: assert property (p_on_reads_running)
    else $error("enable readback wrong");

  property p_cfg_win;
    cfg_q.win |-> win_en;
  endproperty
  a_cfg_win: assert property (p_cfg_win)
    else $error("configured window bit not set");

  property p_key_restarts;
    s_key |=> count == '0 ##1 !ce || count <= 1;
  endproperty
  a_key_restarts: assert property (p_key_restarts)
    else $error("key write did not restart count");

  property p_early_resets;
    ce && early |=> dev_reset && stat[ST_EARLY];
  endproperty
  a_early_resets: assert property (p_early_resets)
    else $error("early clear did not reset");

endmodule

// ---- bench/tb_top.sv ----
/*
  self-checking bench of the dual postscaler watchdog timer.
  assumes dpwdt_pkg is compiled first; clk_sys runs at 200 MHz.
*/
`timescale 1ns/1ps
module tb_top;
  import dpwdt_pkg::*;
  // ------
  // signals
  // ------
  logic          clk_sys, rst, ce, power_save, lpclk_in, fclk_in, cause_clr;
  dpwdt_cfg_s    cfg_bits;
  dpwdt_bus_s    bus;
  logic [DW-1:0] rd_data, rv;
  logic          watchdog_reset_flag, dev_reset, wake_req, irq;
  logic          osc_run, any_rst, any_wake;
  logic [1:0]    osc_div = 2'h0;
  int            num_errors, num_checks, n;

  dpwdt_top dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg_bits(cfg_bits), .power_save(power_save),
    .lpclk_in(lpclk_in), .fclk_in(fclk_in), .bus(bus), .rd_data(rd_data), .cause_clr(cause_clr),
    .watchdog_reset_flag(watchdog_reset_flag), .dev_reset(dev_reset), .wake_req(wake_req), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // both oscillator pins toggle every 4 cycles while enabled
  always @(posedge clk_sys) begin
    osc_div <= osc_div + 2'h1;
    if (osc_run && osc_div == 2'h3) begin
      lpclk_in <= ~lpclk_in;
      fclk_in  <= ~fclk_in;
    end
  end

  // catch event pulses away from the sampling edge
  always @(negedge clk_sys) begin
    if (dev_reset === 1'b1) any_rst = 1'b1;
    if (wake_req === 1'b1) any_wake = 1'b1;
  end

  // ------
  // tasks
  // ------
  task automatic chk(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // counts edges until the chosen event shows, bounded by lim
  task automatic wait_ev(input logic wake, input int start, input int lim, output int cnt);
    cnt = start;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (cnt < lim && (wake ? wake_req : dev_reset) !== 1'b1);
  endtask

  task automatic do_reset(input logic en, win, input logic [4:0] rdv, input logic [1:0] cs,
                          input logic [4:0] sdv);
    @(posedge clk_sys);
    cfg_bits <= '{en: en, win: win, run_div: rdv, clk_sel: cs, slp_div: sdv};
    rst      <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [DW-1:0] ctrl_val(logic on, win, logic [4:0] rdv, logic [1:0] cs, logic [4:0] sdv);
    return {on, 2'b00, rdv, cs, sdv, win};
  endfunction

  // ------
  // scenarios
  // ------
  task automatic t_regs;
    bus_rd(ADDR_CTRL, rv);
    chk("ctrl after reset", rv, ctrl_val(1'b0, 1'b0, 5'h03, 2'h0, 5'h02));
    bus_wr(ADDR_CTRL, 16'hffff);
    bus_rd(ADDR_CTRL, rv);
    chk("ctrl all ones", rv, ctrl_val(1'b1, 1'b1, 5'h03, 2'h0, 5'h02));
    bus_wr(ADDR_CTRL, 16'h0000);
    idle(1);
    bus_rd(ADDR_CTRL, rv);
    chk("ctrl cleared", rv, ctrl_val(1'b0, 1'b0, 5'h03, 2'h0, 5'h02));
    bus_rd(ADDR_KEY, rv);
    chk("key readback", rv, RD_ZERO);
    bus_rd(4'h2, rv);
    chk("unmapped read", rv, RD_ZERO);
  endtask

  task automatic t_run;
    bus_wr(ADDR_MASK, 16'h0001);
    bus_wr(ADDR_CTRL, 16'h8000);
    any_rst = 1'b0;
    repeat (4) begin
      bus_wr(ADDR_KEY, CLEAR_KEY);
      idle(4);
    end
    chk("reset while cleared", 16'(any_rst), 16'h0000);
    bus_wr(ADDR_KEY, CLEAR_KEY);
    bus_wr(ADDR_KEY, 16'h5742);
    wait_ev(1'b0, 2, 40, n);
    chk("run timeout", 16'(n), 16'h0008);
    chk("cause flag", 16'(watchdog_reset_flag), 16'h0001);
    chk("irq on reset", 16'(irq), 16'h0001);
    bus_wr(ADDR_CTRL, 16'h0000);
    idle(1);
    bus_rd(ADDR_STAT, rv);
    chk("status reset", rv, 16'h0001);
    bus_rd(ADDR_STAT, rv);
    chk("status cleared", rv, 16'h0000);
    chk("irq cleared", 16'(irq), 16'h0000);
    @(posedge clk_sys);
    cause_clr <= 1'b1;
    @(posedge clk_sys);
    cause_clr <= 1'b0;
    #1;
    chk("cause flag cleared", 16'(watchdog_reset_flag), 16'h0000);
  endtask

  task automatic t_sleep;
    bus_wr(ADDR_CTRL, 16'h8000);
    @(posedge clk_sys);
    power_save <= 1'b1;
    any_rst = 1'b0;
    any_wake = 1'b0;
    idle(20);
    chk("wake without low-power clock", 16'(any_wake), 16'h0000);
    osc_run <= 1'b1;
    wait_ev(1'b1, 0, 100, n);
    chk("wake pulse", 16'(wake_req), 16'h0001);
    chk("sleep timeout short", 16'(n < 50), 16'h0001);
    chk("reset in sleep", 16'(any_rst), 16'h0000);
    chk("wake masked", 16'(irq), 16'h0000);
    osc_run <= 1'b0;
    bus_wr(ADDR_CTRL, 16'h0000);
    power_save <= 1'b0;
    idle(1);
    bus_rd(ADDR_STAT, rv);
    chk("status wake", rv, 16'h0002);
  endtask

  task automatic t_window;
    bus_wr(ADDR_CTRL, 16'h8001);
    bus_wr(ADDR_KEY, CLEAR_KEY);
    #1;
    chk("early clear", 16'(dev_reset), 16'h0001);
    bus_wr(ADDR_CTRL, 16'h0000);
    idle(1);
    bus_rd(ADDR_STAT, rv);
    chk("early status", 16'(rv[ST_EARLY]), 16'h0001);
  endtask

  task automatic t_clksel;
    for (int cs = 0; cs < 4; cs++) begin
      do_reset(1'b1, cs == 3, 5'h01, 2'(cs), 5'h00);
      bus_wr(ADDR_CTRL, 16'h0000);
      idle(1);
      bus_rd(ADDR_CTRL, rv);
      chk("config ctrl", rv, ctrl_val(1'b1, cs == 3, 5'h01, 2'(cs), 5'h00));
      any_rst = 1'b0;
      idle(12);
      chk("system clock ticks", 16'(any_rst), 16'(cs == 0));
      osc_run <= 1'b1;
      any_rst = 1'b0;
      idle(60);
      osc_run <= 1'b0;
      chk("oscillator ticks", 16'(any_rst), 16'(cs != 1));
    end
  endtask

  // ------
  // main
  // ------
  initial begin
    rst        = 1'b1;
    ce         = 1'b1;
    power_save = 1'b0;
    lpclk_in   = 1'b0;
    fclk_in    = 1'b0;
    cause_clr  = 1'b0;
    bus        = '0;
    osc_run    = 1'b0;
    cfg_bits   = CFG_RST_VAL;
    num_errors = 0;
    num_checks = 0;
    any_rst    = 1'b0;
    any_wake   = 1'b0;
    do_reset(1'b0, 1'b0, 5'h03, 2'h0, 5'h02);
    t_regs;
    t_run;
    t_sleep;
    t_window;
    t_clksel;
    stop_test;
  end

  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
endmodule
